//--- rtl/serial_pkg.sv
// Constants, register map and carrier types of the asynchronous serial port.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
package serial_pkg;

  // ==========================================================================
  // Register map (byte addresses).
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_BAUD = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;

  // ==========================================================================
  // Field positions of control register one.
  localparam int C1_RX9 = 7;
  localparam int C1_TX9 = 6;
  localparam int C1_LEN = 4;
  localparam int C1_WAKE = 3;

  // ==========================================================================
  // Reset values and bus answers.
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'hC0;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [4:0] BAUD_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Timing: sixteen samples per bit, majority taken over samples 7, 8 and 9.
  localparam logic [15:0] PRESCALE_DEF = 16'h0004;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_C = 4'h9;
  localparam logic [7:0] IDLE_TICKS_8 = 8'hA0;
  localparam logic [7:0] IDLE_TICKS_9 = 8'hB0;
  localparam logic [3:0] FRAME_8 = 4'hA;
  localparam logic [3:0] FRAME_9 = 4'hB;

  // ==========================================================================
  // Carrier types.
  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rie;
    logic ilie;
    logic te;
    logic re;
    logic rwu;
    logic sbk;
  } ctrl2_s;

  typedef struct packed {
    logic tx_data_empty_flag;
    logic tc;
    logic rdrf;
    logic idle;
    logic ovr;
    logic nf;
    logic fe;
    logic rsv;
  } stat_s;

  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
  } rx_state_e;

endpackage : serial_pkg

//--- rtl/async_serial_port.sv
// Asynchronous serial port: transmitter, receiver, shared baud generator.
// Assumes an AXI4-Lite master on aclk and a remote NRZ serial device on the pins.

// How it works
// - Transmitter and receiver run separately but both time their bits from one sample tick.
// - Software picks one of 32 bit rates through a five-bit rate select.
// - Frames are NRZ mark/space with the transmit and receive lines active at the same time.
// - A length bit selects 9-bit characters when set and 8-bit when clear, and reset leaves it.
// - The stored ninth transmit bit enters the shifter together with the data byte.
// - The ninth bit is carried as plain data with no parity or stop meaning.
// - A wake bit picks address-mark wakeup when set and idle-line wakeup when clear.
// - The transmit-empty interrupt enable gates the empty flag and is cleared by reset.
// - The transmit-done interrupt enable gates the done flag and is cleared by reset.
// - Seven flags can interrupt: tx empty, tx done, rx full, overrun, idle line, noise and framing error.
// - A stop bit sampled low raises the framing error flag when the character enters the receive buffer.
// - Control two holds tx empty, tx done, rx and idle interrupt enables, tx and rx enables, wakeup and break.
// - Any enabled and unmasked flag that is set drives one shared interrupt line.
module async_serial_port #(
  parameter logic [15:0] PRESCALE = serial_pkg::PRESCALE_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic rx_data_pin,
  output logic tx_pin,
  output logic irq
);

  // ==========================================================================
  // Bus state.
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt, bvalid_r, bvalid_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt, w_data_r, w_data_nxt;
  logic w_lane_r, w_lane_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_go, wr_hit, rd_hit;
  logic [7:0] rd_val;

  // Software registers.
  serial_pkg::ctrl2_s ctrl2_r, ctrl2_nxt;
  serial_pkg::stat_s stat_r, stat_nxt, stat_set, stat_clr, rx_set;
  logic [7:0] mask_r, mask_nxt;
  logic [4:0] baud_r, baud_nxt;
  logic tx_ninth_bit, tx_ninth_nxt, len9_r, len9_nxt, wake_r, wake_nxt;
  logic [7:0] tdata_r, tdata_nxt;
  logic tfull_r, tfull_nxt;

  // Baud generator.
  logic [15:0] bcnt_r, bcnt_nxt, div;
  logic tick;

  // Transmitter.
  serial_pkg::tx_state_e tst_r, tst_nxt;
  logic [10:0] tsh_r, tsh_nxt;
  logic [3:0] tt_r, tt_nxt, tb_r, tb_nxt, frame;
  logic tbrk_r, tbrk_nxt;

  // Receiver.
  logic rs1_r, rs2_r;
  serial_pkg::rx_state_e rst_r, rst_nxt;
  logic [3:0] st_r, st_nxt, rb_r, rb_nxt;
  logic [2:0] smp_r, smp_nxt;
  logic [8:0] rsh_r, rsh_nxt, rx_word;
  logic [7:0] rbuf_r, rbuf_nxt, icnt_r, icnt_nxt, ilim;
  logic rx9_r, rx9_nxt, noisy_r, noisy_nxt, armed_r, armed_nxt;
  logic maj, msb, rwu_clr;

  // ==========================================================================
  // Bus handshakes: address and data are taken in either order.
  assign awready = !aw_full_r;
  assign wready = !w_full_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign wr_go = aw_full_r && w_full_r && !bvalid_r;
  assign wr_hit = aw_addr_r <= serial_pkg::ADDR_MASK && aw_addr_r[1:0] == 2'h0;
  assign rd_hit = araddr <= serial_pkg::ADDR_MASK && araddr[1:0] == 2'h0;

  // Read data selection.
  always_comb begin
    case (araddr)
      serial_pkg::ADDR_DATA: rd_val = rbuf_r;
      serial_pkg::ADDR_CTRL1: rd_val = {rx9_r, tx_ninth_bit, 1'b0, len9_r, wake_r, 3'h0};
      serial_pkg::ADDR_CTRL2: rd_val = ctrl2_r;
      serial_pkg::ADDR_STAT: rd_val = stat_r;
      serial_pkg::ADDR_BAUD: rd_val = {3'h0, baud_r};
      serial_pkg::ADDR_MASK: rd_val = mask_r;
      default: rd_val = 8'h00;
    endcase
  end

  // Bus channel state, register writes and flag bookkeeping.
  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt = w_full_r;
    w_data_nxt = w_data_r;
    w_lane_nxt = w_lane_r;
    bvalid_nxt = bvalid_r && !bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    ctrl2_nxt = ctrl2_r;
    mask_nxt = mask_r;
    baud_nxt = baud_r;
    tx_ninth_nxt = tx_ninth_bit;
    len9_nxt = len9_r;
    wake_nxt = wake_r;
    tdata_nxt = tdata_r;
    stat_clr = '0;
    if (awvalid && awready) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_full_nxt = 1'b1;
      w_data_nxt = wdata[7:0];
      w_lane_nxt = wstrb[0];
    end
    if (wr_go) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? serial_pkg::RESP_OKAY : serial_pkg::RESP_SLVERR;
      if (w_lane_r) begin
        case (aw_addr_r)
          serial_pkg::ADDR_DATA: begin
            tdata_nxt = w_data_r;
            stat_clr.tx_data_empty_flag = 1'b1;
            stat_clr.tc = 1'b1;
          end
          serial_pkg::ADDR_CTRL1: begin
            tx_ninth_nxt = w_data_r[serial_pkg::C1_TX9];
            len9_nxt = w_data_r[serial_pkg::C1_LEN];
            wake_nxt = w_data_r[serial_pkg::C1_WAKE];
          end
          serial_pkg::ADDR_CTRL2: ctrl2_nxt = w_data_r;
          serial_pkg::ADDR_STAT: stat_clr = w_data_r;
          serial_pkg::ADDR_BAUD: baud_nxt = w_data_r[4:0];
          serial_pkg::ADDR_MASK: mask_nxt = w_data_r;
          default: ;
        endcase
      end
    end
    if (rwu_clr) begin
      ctrl2_nxt.rwu = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h0, rd_val};
      rresp_nxt = rd_hit ? serial_pkg::RESP_OKAY : serial_pkg::RESP_SLVERR;
    end
    // A hardware set in the same cycle as a clear wins.
    stat_nxt = (stat_r & ~stat_clr) | stat_set | rx_set;
    stat_nxt.rsv = 1'b0;
  end

  // Shared interrupt: each flag passes the mask and its enable, overrun sharing rie with rx full; noise and framing error pass the mask only.
  always_comb begin
    irq = |(stat_r & mask_r & {ctrl2_r.tx_empty_irq_en, ctrl2_r.tx_done_irq_en, ctrl2_r.rie, ctrl2_r.ilie,
                               ctrl2_r.rie, 3'h7});
  end

  // Bus and control registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      bresp_r <= serial_pkg::RESP_OKAY;
      rresp_r <= serial_pkg::RESP_OKAY;
      rdata_r <= 32'h00000000;
      ctrl2_r <= serial_pkg::CTRL2_RST;
      stat_r <= serial_pkg::STAT_RST;
      mask_r <= serial_pkg::MASK_RST;
      baud_r <= serial_pkg::BAUD_RST;
      tdata_r <= 8'h00;
    end else if (ce) begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_lane_r <= w_lane_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ctrl2_r <= ctrl2_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      baud_r <= baud_nxt;
      tdata_r <= tdata_nxt;
    end
  end

  // Length, wake and ninth transmit bit are untouched by reset.
  always_ff @(posedge aclk) begin
    if (ce) begin
      tx_ninth_bit <= tx_ninth_nxt;
      len9_r <= len9_nxt;
      wake_r <= wake_nxt;
    end
  end

  // ==========================================================================
  // Baud generator: one sample tick every (select + 1) * PRESCALE clocks.
  assign div = 16'(16'({11'h0, baud_r} + 16'h1) * PRESCALE) - 16'h1;
  assign tick = bcnt_r == 16'h0;
  assign bcnt_nxt = tick ? div : bcnt_r - 16'h1;
  assign frame = len9_r ? serial_pkg::FRAME_9 : serial_pkg::FRAME_8;

  // ==========================================================================
  // Transmitter: buffer byte moves to the shifter, then LSB first at one bit per 16 ticks.
  always_comb begin
    tst_nxt = tst_r;
    tsh_nxt = tsh_r;
    tt_nxt = tt_r;
    tb_nxt = tb_r;
    tbrk_nxt = tbrk_r;
    tfull_nxt = tfull_r || (wr_go && w_lane_r && aw_addr_r == serial_pkg::ADDR_DATA);
    stat_set = '0;
    case (tst_r)
      serial_pkg::TX_IDLE: begin
        if (ctrl2_r.te && tfull_r) begin
          tsh_nxt = {1'b1, len9_r ? tx_ninth_bit : 1'b1, tdata_r, 1'b0};
          tfull_nxt = wr_go && w_lane_r && aw_addr_r == serial_pkg::ADDR_DATA;
          stat_set.tx_data_empty_flag = !tfull_nxt;
          tst_nxt = serial_pkg::TX_SHIFT;
          tt_nxt = 4'h0;
          tb_nxt = 4'h0;
          tbrk_nxt = 1'b0;
        end else if (ctrl2_r.te && ctrl2_r.sbk) begin
          tsh_nxt = 11'h000;
          tst_nxt = serial_pkg::TX_SHIFT;
          tt_nxt = 4'h0;
          tb_nxt = 4'h0;
          tbrk_nxt = 1'b1;
        end
      end
      serial_pkg::TX_SHIFT: begin
        if (tick) begin
          tt_nxt = tt_r + 4'h1;
          if (tt_r == serial_pkg::TICK_LAST) begin
            tsh_nxt = {1'b1, tsh_r[10:1]};
            tb_nxt = tb_r + 4'h1;
            if (tb_r == frame - 4'h1) begin
              tst_nxt = serial_pkg::TX_IDLE;
              stat_set.tc = !tfull_r && !ctrl2_r.sbk;
            end
          end
        end
      end
      default: tst_nxt = serial_pkg::TX_IDLE;
    endcase
  end

  // Transmit line idles high; the shifter drives it only during a frame.
  always_comb begin
    tx_pin = (tst_r == serial_pkg::TX_SHIFT) ? tsh_r[0] : !(tbrk_r && ctrl2_r.te && ctrl2_r.sbk);
  end

  // ==========================================================================
  // Receiver: majority of three mid-bit samples, noise when they disagree.
  assign maj = (smp_r[0] & smp_r[1]) | (smp_r[1] & smp_r[2]) | (smp_r[0] & smp_r[2]);
  assign rx_word = len9_r ? rsh_r : {1'b0, rsh_r[8:1]};
  assign msb = rsh_r[8];
  assign ilim = len9_r ? serial_pkg::IDLE_TICKS_9 : serial_pkg::IDLE_TICKS_8;

  always_comb begin
    rst_nxt = rst_r;
    st_nxt = st_r;
    rb_nxt = rb_r;
    smp_nxt = smp_r;
    rsh_nxt = rsh_r;
    rbuf_nxt = rbuf_r;
    rx9_nxt = rx9_r;
    noisy_nxt = noisy_r;
    armed_nxt = armed_r;
    icnt_nxt = icnt_r;
    rwu_clr = 1'b0;
    rx_set = '0;
    if (tick && ctrl2_r.re) begin
      st_nxt = st_r + 4'h1;
      if (st_r >= serial_pkg::SMP_A && st_r <= serial_pkg::SMP_C) begin
        smp_nxt = {smp_r[1:0], rs2_r};
      end
      // Idle line: a full character time of high level.
      icnt_nxt = (rs2_r && icnt_r != ilim) ? icnt_r + 8'h1 : (rs2_r ? icnt_r : 8'h00);
      if (icnt_nxt == ilim && icnt_r != ilim) begin
        rwu_clr = !wake_r && ctrl2_r.rwu;
        rx_set.idle = armed_r && !ctrl2_r.rwu;
        armed_nxt = 1'b0;
      end
      case (rst_r)
        serial_pkg::RX_IDLE: begin
          st_nxt = 4'h0;
          if (!rs2_r) begin
            rst_nxt = serial_pkg::RX_START;
            st_nxt = 4'h1;
            noisy_nxt = 1'b0;
          end
        end
        serial_pkg::RX_START: begin
          if (st_r == serial_pkg::TICK_LAST) begin
            noisy_nxt = noisy_r || !(&smp_r || ~|smp_r);
            rst_nxt = maj ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
            rb_nxt = 4'h0;
          end
        end
        serial_pkg::RX_DATA: begin
          if (st_r == serial_pkg::TICK_LAST) begin
            noisy_nxt = noisy_r || !(&smp_r || ~|smp_r);
            rsh_nxt = {maj, rsh_r[8:1]};
            rb_nxt = rb_r + 4'h1;
            if (rb_r == frame - 4'h3) begin
              rst_nxt = serial_pkg::RX_STOP;
            end
          end
        end
        serial_pkg::RX_STOP: begin
          if (st_r == serial_pkg::TICK_LAST) begin
            rst_nxt = serial_pkg::RX_IDLE;
            armed_nxt = 1'b1;
            if (!ctrl2_r.rwu || (wake_r && msb)) begin
              rwu_clr = ctrl2_r.rwu;
              if (stat_r.rdrf) begin
                rx_set.ovr = 1'b1;
              end else begin
                rbuf_nxt = rx_word[7:0];
                rx9_nxt = rx_word[8];
                rx_set.rdrf = 1'b1;
                rx_set.fe = !maj;
                rx_set.nf = noisy_r || !(&smp_r || ~|smp_r);
              end
            end
          end
        end
        default: rst_nxt = serial_pkg::RX_IDLE;
      endcase
    end
  end

  // Transmitter, receiver and baud generator registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bcnt_r <= 16'h0000;
      tst_r <= serial_pkg::TX_IDLE;
      tsh_r <= 11'h7FF;
      tt_r <= 4'h0;
      tb_r <= 4'h0;
      tbrk_r <= 1'b0;
      tfull_r <= 1'b0;
      rs1_r <= 1'b1;
      rs2_r <= 1'b1;
      rst_r <= serial_pkg::RX_IDLE;
      st_r <= 4'h0;
      rb_r <= 4'h0;
      smp_r <= 3'h7;
      rsh_r <= 9'h000;
      rbuf_r <= 8'h00;
      rx9_r <= 1'b0;
      noisy_r <= 1'b0;
      armed_r <= 1'b0;
      icnt_r <= 8'h00;
    end else if (ce) begin
      bcnt_r <= bcnt_nxt;
      tst_r <= tst_nxt;
      tsh_r <= tsh_nxt;
      tt_r <= tt_nxt;
      tb_r <= tb_nxt;
      tbrk_r <= tbrk_nxt;
      tfull_r <= tfull_nxt;
      rs1_r <= rx_data_pin;
      rs2_r <= rs1_r;
      rst_r <= rst_nxt;
      st_r <= st_nxt;
      rb_r <= rb_nxt;
      smp_r <= smp_nxt;
      rsh_r <= rsh_nxt;
      rbuf_r <= rbuf_nxt;
      rx9_r <= rx9_nxt;
      noisy_r <= noisy_nxt;
      armed_r <= armed_nxt;
      icnt_r <= icnt_nxt;
    end
  end

endmodule : async_serial_port

//--- tb/async_serial_port_monitor.sv
// Checker of the serial port's bus answers, reset state and line timing.
// Assumes it is bound to the port's top module and sees its ports only.
module async_serial_port_monitor #(
  parameter logic [15:0] PRESCALE = serial_pkg::PRESCALE_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic tx_pin,
  input wire logic irq
);
  localparam int MIN_RUN = 16 * int'(PRESCALE);
  logic tx_q_r;
  logic seen_r;
  logic [15:0] run_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Counts how long the transmit line has kept its present level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_q_r <= 1'b1;
      seen_r <= 1'b0;
      run_r <= 16'h0000;
    end else begin
      tx_q_r <= tx_pin;
      if (tx_pin != tx_q_r) begin
        seen_r <= 1'b1;
        run_r <= 16'h0001;
      end else if (run_r != 16'hFFFF) begin
        run_r <= run_r + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Line timing, reset state and bus answers.
  property p_bit_len;
    seen_r && (tx_pin != tx_q_r) |-> run_r >= 16'(MIN_RUN);
  endproperty
  a_bit_len: assert property (p_bit_len)
    else $error("transmit level shorter than one bit");
  property p_rst;
    $rose(aresetn) |-> tx_pin && !irq && !bvalid && !rvalid;
  endproperty
  a_rst: assert property (p_rst)
    else $error("wrong state after reset");
  property p_b_ans;
    awvalid && awready && wvalid && wready |=> ##1 bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans)
    else $error("write answer late");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped");
  property p_r_ans;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans)
    else $error("read answer late");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped");
  property p_r_upper;
    rvalid |-> rdata[31:8] == 24'h000000 && !arready;
  endproperty
  a_r_upper: assert property (p_r_upper)
    else $error("read upper bits or ready wrong");
  property p_b_code;
    bvalid |-> bresp == serial_pkg::RESP_OKAY || bresp == serial_pkg::RESP_SLVERR;
  endproperty
  a_b_code: assert property (p_b_code)
    else $error("bad write response code");

  // Main scenarios reached.
  c_tx: cover property ($fell(tx_pin));
  c_irq: cover property ($rose(irq));
  c_err: cover property (bvalid && bresp == serial_pkg::RESP_SLVERR);
endmodule : async_serial_port_monitor

bind async_serial_port async_serial_port_monitor #(.PRESCALE(PRESCALE)) async_serial_port_monitor_i (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .rresp(rresp), .tx_pin(tx_pin), .irq(irq)
);

//--- tb/serial_remote.sv
// Remote serial device: sends NRZ frames on its line and decodes the port's output.
// Assumes bit_clks clocks per bit, changed by the bench only between frames.
module serial_remote (
  input wire logic aclk,
  input wire logic tx_pin,
  input wire logic [15:0] bit_clks,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line rests at mark.
  initial rx_line = 1'b1;

  // Sends start, data low bit first, an optional ninth bit and stop; gl upsets bit 0.
  task automatic send(input logic [8:0] d, input logic nine, input logic stop, input logic gl);
    logic [10:0] f;
    int n;
    f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < bit_clks; k++) begin
        @(posedge aclk);
        rx_line <= f[i] ^ (gl && i == 1 && k == bit_clks / 2);
      end
    end
    @(posedge aclk);
    rx_line <= 1'b1;
  endtask : send

  // Waits for a start bit, then samples each data bit in its middle.
  task automatic recv(output logic [8:0] d, input logic nine);
    d = 9'h000;
    do @(posedge aclk); while (tx_pin !== 1'b0);
    repeat (bit_clks / 2) @(posedge aclk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (bit_clks) @(posedge aclk);
      d[i] = tx_pin;
    end
  endtask : recv
endmodule : serial_remote

//--- tb/tb_async_serial_port.sv
// Self-checking bench of the serial port over its register bus and pins.
// Assumes the remote model on the pins and a sample tick every clock at rate zero.
module tb_async_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rx_line;
  logic awready, wready, bvalid, arready, rvalid, tx_pin, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d32;
  logic [1:0] bresp, rresp, lb, lr;
  logic [15:0] bit_clks;
  logic [8:0] got;
  logic [7:0] cv [4] = '{8'h8C, 8'h0C, 8'h4C, 8'h4C};
  logic [7:0] mv [4] = '{8'h80, 8'h80, 8'h40, 8'h00};
  logic [4:0] bv [2] = '{5'h03, 5'h1F};
  int err_count, checked, cyc;

  async_serial_port #(.PRESCALE(16'h0001)) async_serial_port_i (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .rx_data_pin(rx_line), .tx_pin(tx_pin), .irq(irq)
  );
  serial_remote serial_remote_i (
    .aclk(aclk), .tx_pin(tx_pin), .bit_clks(bit_clks), .rx_line(rx_line)
  );

  // ==========================================================================
  // Clock and a watchdog that ends a hung run.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      results();
    end
  end

  // ==========================================================================
  // Verdict, comparison and bus tasks.
  task automatic results();
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rst();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h000000, d};
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        lb = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        lr = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d & {24'hFFFFFF, m}, {24'h000000, e});
  endtask : rc
  // One character each way at once, then the received byte and ninth bit are read.
  task automatic xfer(input logic [8:0] t, input logic [8:0] r, input logic nine);
    wr(serial_pkg::ADDR_CTRL1, {1'b0, t[8], 1'b0, nine, 4'h0});
    fork
      wr(serial_pkg::ADDR_DATA, t[7:0]);
      serial_remote_i.recv(got, nine);
      serial_remote_i.send(r, nine, 1'b1, 1'b0);
    join
    chk({23'h000000, got}, {23'h000000, t & {nine, 8'hFF}});
    repeat (8) @(posedge aclk);
    rc(serial_pkg::ADDR_DATA, 8'hFF, r[7:0]);
    rc(serial_pkg::ADDR_CTRL1, {nine, 7'h00}, {r[8] & nine, 7'h00});
    wr(serial_pkg::ADDR_STAT, 8'h3E);
  endtask : xfer

  // ==========================================================================
  // Main sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    bit_clks = 16'h0010;
    rst();
    rc(serial_pkg::ADDR_CTRL2, 8'hFF, serial_pkg::CTRL2_RST);
    rc(serial_pkg::ADDR_STAT, 8'hFF, serial_pkg::STAT_RST);
    rc(serial_pkg::ADDR_MASK, 8'hFF, serial_pkg::MASK_RST);
    rc(serial_pkg::ADDR_BAUD, 8'h1F, 8'h00);
    rd(8'h18, d32);
    chk({30'h0, lr}, {30'h0, serial_pkg::RESP_SLVERR});
    wr(8'h18, 8'h00);
    chk({30'h0, lb}, {30'h0, serial_pkg::RESP_SLVERR});
    wr(serial_pkg::ADDR_CTRL2, 8'h0C);
    chk({30'h0, lb}, {30'h0, serial_pkg::RESP_OKAY});
    xfer(9'h0A5, 9'h03C, 1'b0);
    xfer(9'h181, 9'h1C3, 1'b1);
    xfer(9'h07E, 9'h100, 1'b1);
    for (int i = 0; i < 2; i++) begin
      wr(serial_pkg::ADDR_BAUD, {3'h0, bv[i]});
      bit_clks <= 16'h0010 * ({11'h000, bv[i]} + 16'h0001);
      xfer(9'h05A, 9'h0A5, 1'b0);
    end
    // Length, ninth and wake bits survive a reset; the enables do not.
    wr(serial_pkg::ADDR_CTRL1, 8'h58);
    wr(serial_pkg::ADDR_CTRL2, 8'hCC);
    rst();
    rc(serial_pkg::ADDR_CTRL1, 8'h58, 8'h58);
    rc(serial_pkg::ADDR_CTRL2, 8'hFF, 8'h00);
    bit_clks <= 16'h0010;
    wr(serial_pkg::ADDR_CTRL1, 8'h00);
    wr(serial_pkg::ADDR_CTRL2, 8'h0C);
    // Framing, noise and overrun on received characters.
    serial_remote_i.send(9'h055, 1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge aclk);
    rc(serial_pkg::ADDR_STAT, 8'h02, 8'h02);
    repeat (300) @(posedge aclk);
    wr(serial_pkg::ADDR_STAT, 8'h3E);
    serial_remote_i.send(9'h055, 1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge aclk);
    rc(serial_pkg::ADDR_STAT, 8'h26, 8'h24);
    rc(serial_pkg::ADDR_DATA, 8'hFF, 8'h55);
    wr(serial_pkg::ADDR_STAT, 8'h3E);
    serial_remote_i.send(9'h011, 1'b0, 1'b1, 1'b0);
    serial_remote_i.send(9'h022, 1'b0, 1'b1, 1'b0);
    repeat (8) @(posedge aclk);
    rc(serial_pkg::ADDR_STAT, 8'h28, 8'h28);
    rc(serial_pkg::ADDR_DATA, 8'hFF, 8'h11);
    wr(serial_pkg::ADDR_STAT, 8'h3E);
    // Address-mark wakeup: a low top bit is dropped, a high one wakes and is kept.
    wr(serial_pkg::ADDR_CTRL1, 8'h08);
    wr(serial_pkg::ADDR_CTRL2, 8'h0E);
    serial_remote_i.send(9'h011, 1'b0, 1'b1, 1'b0);
    repeat (8) @(posedge aclk);
    rc(serial_pkg::ADDR_STAT, 8'h20, 8'h00);
    serial_remote_i.send(9'h091, 1'b0, 1'b1, 1'b0);
    repeat (8) @(posedge aclk);
    rc(serial_pkg::ADDR_STAT, 8'h20, 8'h20);
    rc(serial_pkg::ADDR_DATA, 8'hFF, 8'h91);
    rc(serial_pkg::ADDR_CTRL2, 8'h02, 8'h00);
    wr(serial_pkg::ADDR_STAT, 8'h3E);
    // Idle line raises its flag and, when enabled and unmasked, the interrupt; tx empty and done need enable and mask too.
    repeat (200) @(posedge aclk);
    rc(serial_pkg::ADDR_STAT, 8'h10, 8'h10);
    wr(serial_pkg::ADDR_MASK, 8'h10);
    wr(serial_pkg::ADDR_CTRL2, 8'h1C);
    chk({31'h0, irq}, 32'h00000001);
    wr(serial_pkg::ADDR_STAT, 8'h10);
    chk({31'h0, irq}, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      wr(serial_pkg::ADDR_CTRL2, cv[i]);
      wr(serial_pkg::ADDR_MASK, mv[i]);
      chk({31'h0, irq}, {31'h0, |(cv[i][7:6] & mv[i][7:6])});
    end
    // Break holds the line low until cleared, then the line returns to mark.
    wr(serial_pkg::ADDR_CTRL2, 8'h09);
    repeat (300) @(posedge aclk);
    chk({31'h0, tx_pin}, 32'h00000000);
    wr(serial_pkg::ADDR_CTRL2, 8'h08);
    repeat (400) @(posedge aclk);
    chk({31'h0, tx_pin}, 32'h00000001);
    results();
  end
endmodule : tb_async_serial_port
